// [hw/tms_defines.svh]
// constants of the transceive mode settings block
`ifndef TMS_DEFINES_SVH
`define TMS_DEFINES_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define TMS_ADR_MODE 8'h00
`define TMS_ADR_STATUS 8'h04
`define TMS_ADR_MASK 8'h08

// ****************************************************************
// mode register layout and reset
// ****************************************************************
`define TMS_MODE_RESET 8'h3B
`define TMS_BIT_ORDER 7
`define TMS_BIT_SYNC 6
`define TMS_BIT_TX_WAIT 5
`define TMS_BIT_RX_WAIT 4
`define TMS_BIT_POLARITY 3
`define TMS_BIT_DET_OFF 2
`define TMS_PRESET_HI 1
`define TMS_PRESET_LO 0

// ****************************************************************
// status bits, presets, sync byte
// ****************************************************************
`define TMS_EVT_ENVELOPE 0
`define TMS_EVT_SYNC 1
`define TMS_EVT_WIDTH 2
`define TMS_SYNC_BYTE 8'hF0
`define TMS_PRESET_00 16'h0000
`define TMS_PRESET_01 16'h6363
`define TMS_PRESET_10 16'hA671
`define TMS_PRESET_FRAME_A 16'h6363
`define TMS_PRESET_FRAME_B 16'hFFFF
`define TMS_PRESET_FRAME_F 16'h0000

`endif

// [hw/tms_pkg.sv]
// types of the transceive mode settings block
package tms_pkg;

   typedef enum logic [1:0]
   {
      TX_IDLE,
      TX_WAIT_FIELD,
      TX_SYNC,
      TX_GO
   } tms_tx_state_type;

endpackage

// [hw/tms_sync_gate.sv]
// receiver gate that waits for the sync byte
`timescale 1ns/100ps
`default_nettype none
`include "tms_defines.svh"

module tms_sync_gate
   import tms_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic detect_en,
   input wire logic rx_frame_start,
   input wire logic rx_byte_valid,
   input wire logic [7:0] rx_byte,
   output logic rx_enable_q,
   output logic sync_seen_q
);

   logic seen_q;
   logic seen_d;
   logic rx_enable_d;
   logic sync_seen_d;

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb
   begin
      seen_d = seen_q;
      sync_seen_d = 1'b0;
      if (rx_frame_start)
      begin
         seen_d = 1'b0;
      end
      else if (detect_en && !seen_q && rx_byte_valid &&
               rx_byte == `TMS_SYNC_BYTE)
      begin
         seen_d = 1'b1;
         sync_seen_d = 1'b1;
      end
      rx_enable_d = !detect_en || seen_d;
   end

   // ****************************************************************
   // registers
   // ****************************************************************
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         seen_q <= 1'b0;
         rx_enable_q <= 1'b0;
         sync_seen_q <= 1'b0;
      end
      else
      begin
         seen_q <= seen_d;
         rx_enable_q <= rx_enable_d;
         sync_seen_q <= sync_seen_d;
      end
   end

endmodule
`default_nettype wire

// [hw/tms_top.sv]
// general mode settings register and its steering logic
`timescale 1ns/100ps
`default_nettype none
`include "tms_defines.svh"

// Functional notes
// - With bit 7 set the checksum runs high bit first.
// - The bit order control is ignored while radio communication is in progress.
// - With sync detect set the receiver stays off until byte F0h has been seen.
// - With sync detect set every outgoing frame is preceded by the byte F0h.
// - With send after field on set an initiator waits for its own field before sending.
// - With rx delay after field set the receive guard counter waits for an outside field in target role.
// - The envelope input pin is active high when the polarity bit is 1 and active low when 0.
// - The internal envelope signal is always active low.
// - Any change of the polarity bit raises the envelope activity event.
// - The mode detector disable bit switches the mode detector off.
// - The mode detector runs only during the automatic anticollision command.
// - The preset field gives 0000, 6363 or A671 for the standalone checksum command.
// - During communication the preset follows the framing settings, not the field.
module tms_top
   import tms_pkg::*;
(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic irq_q,
   input wire logic rf_comm_active,
   input wire logic tx_active,
   input wire logic [1:0] receive_framing_setting,
   input wire logic [1:0] transmit_framing_setting,
   output logic crc_high_bit_order_q,
   output logic [15:0] checksum_preset_q,
   input wire logic rx_frame_start,
   input wire logic rx_byte_valid,
   input wire logic [7:0] rx_byte,
   output logic rx_receive_enable_q,
   input wire logic tx_start_req,
   input wire logic initiator_role,
   input wire logic own_field_on,
   output logic tx_sync_valid_q,
   output logic [7:0] tx_sync_byte_q,
   output logic tx_launch_q,
   input wire logic rx_guard_arm,
   input wire logic target_role,
   input wire logic ext_field_detected,
   output logic receive_guard_counter_en_q,
   input wire logic envelope_input_pin,
   output logic envelope_active_n_q,
   input wire logic anticollision_busy,
   output logic mode_detector_en_q
);

   logic rst_meta_q, rst_n_q, ack_d, irq_d, access, wr_mode, rd_status;
   logic env_n_d, env_prev_q, sync_seen, order_d, guard_d, det_d;
   logic tx_wait_needed;
   logic [7:0] mode_q, mode_d;
   logic [1:0] status_q, status_d, mask_q, mask_d, events, frame_code;
   logic [31:0] rdata_d;
   logic [15:0] preset_d;
   tms_tx_state_type tx_st_q, tx_st_d;

   // ****************************************************************
   // reset release
   // ****************************************************************
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end

   // ****************************************************************
   // wishbone slave and registers
   // ****************************************************************
   assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr_mode = access && wb_we_i && wb_sel_i[0] &&
                    wb_adr_i == `TMS_ADR_MODE;
   assign rd_status = access && !wb_we_i && wb_adr_i == `TMS_ADR_STATUS;

   always_comb
   begin
      mode_d = mode_q;
      mask_d = mask_q;
      ack_d = access;
      rdata_d = 32'h0000_0000;
      if (wr_mode)
      begin
         mode_d = wb_dat_i[7:0];
      end
      if (access && wb_we_i && wb_sel_i[0] &&
          wb_adr_i == `TMS_ADR_MASK)
      begin
         mask_d = wb_dat_i[1:0];
      end
      if (access && !wb_we_i)
      begin
         case (wb_adr_i)
            `TMS_ADR_MODE: rdata_d = {24'h00_0000, mode_q};
            `TMS_ADR_STATUS: rdata_d = {30'h0000_0000, status_q};
            `TMS_ADR_MASK: rdata_d = {30'h0000_0000, mask_q};
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end

   // ****************************************************************
   // events and interrupt
   // ****************************************************************
   always_comb
   begin
      events = 2'b00;
      events[`TMS_EVT_ENVELOPE] = (wr_mode &&
         wb_dat_i[`TMS_BIT_POLARITY] != mode_q[`TMS_BIT_POLARITY]) ||
         (env_prev_q && !envelope_active_n_q);
      events[`TMS_EVT_SYNC] = sync_seen;
      status_d = status_q;
      if (rd_status)
      begin
         status_d = 2'b00;
      end
      status_d = status_d | events;
      irq_d = |(status_d & mask_d);
   end

   always_ff @(posedge ref_clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         mode_q <= `TMS_MODE_RESET;
         mask_q <= 2'b00;
         status_q <= 2'b00;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         irq_q <= 1'b0;
      end
      else
      begin
         mode_q <= mode_d;
         mask_q <= mask_d;
         status_q <= status_d;
         wb_ack_o <= ack_d;
         wb_dat_o <= rdata_d;
         irq_q <= irq_d;
      end
   end

   // ****************************************************************
   // checksum controls
   // ****************************************************************
   assign frame_code = tx_active ? transmit_framing_setting :
                       receive_framing_setting;

   always_comb
   begin
      order_d = mode_q[`TMS_BIT_ORDER] && !rf_comm_active;
      preset_d = `TMS_PRESET_00;
      if (rf_comm_active)
      begin
         case (frame_code)
            2'b00: preset_d = `TMS_PRESET_FRAME_A;
            2'b11: preset_d = `TMS_PRESET_FRAME_B;
            default: preset_d = `TMS_PRESET_FRAME_F;
         endcase
      end
      else
      begin
         case (mode_q[`TMS_PRESET_HI:`TMS_PRESET_LO])
            2'b00: preset_d = `TMS_PRESET_00;
            2'b01: preset_d = `TMS_PRESET_01;
            2'b10: preset_d = `TMS_PRESET_10;
            default: preset_d = `TMS_PRESET_00;
         endcase
      end
   end

   // ****************************************************************
   // field waits, envelope and mode detector
   // ****************************************************************
   always_comb
   begin
      guard_d = rx_guard_arm && (!mode_q[`TMS_BIT_RX_WAIT] ||
                !target_role || ext_field_detected);
      env_n_d = mode_q[`TMS_BIT_POLARITY] ? !envelope_input_pin :
                envelope_input_pin;
      det_d = !mode_q[`TMS_BIT_DET_OFF] && anticollision_busy;
   end

   always_ff @(posedge ref_clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         crc_high_bit_order_q <= 1'b0;
         checksum_preset_q <= 16'h0000;
         receive_guard_counter_en_q <= 1'b0;
         envelope_active_n_q <= 1'b1;
         env_prev_q <= 1'b1;
         mode_detector_en_q <= 1'b0;
      end
      else
      begin
         crc_high_bit_order_q <= order_d;
         checksum_preset_q <= preset_d;
         receive_guard_counter_en_q <= guard_d;
         envelope_active_n_q <= env_n_d;
         env_prev_q <= envelope_active_n_q;
         mode_detector_en_q <= det_d;
      end
   end

   // ****************************************************************
   // receive sync gate
   // ****************************************************************
   tms_sync_gate u_sync_gate
   (
      .clk(ref_clk),
      .rst_n(rst_n_q),
      .detect_en(mode_q[`TMS_BIT_SYNC]),
      .rx_frame_start(rx_frame_start),
      .rx_byte_valid(rx_byte_valid),
      .rx_byte(rx_byte),
      .rx_enable_q(rx_receive_enable_q),
      .sync_seen_q(sync_seen)
   );

   // ****************************************************************
   // transmit start sequencer
   // ****************************************************************
   assign tx_wait_needed = mode_q[`TMS_BIT_TX_WAIT] && initiator_role &&
                           !own_field_on;

   always_comb
   begin
      tx_st_d = tx_st_q;
      case (tx_st_q)
         TX_IDLE:
         begin
            if (tx_start_req)
            begin
               if (tx_wait_needed)
               begin
                  tx_st_d = TX_WAIT_FIELD;
               end
               else if (mode_q[`TMS_BIT_SYNC])
               begin
                  tx_st_d = TX_SYNC;
               end
               else
               begin
                  tx_st_d = TX_GO;
               end
            end
         end
         TX_WAIT_FIELD:
         begin
            if (!tx_wait_needed)
            begin
               tx_st_d = mode_q[`TMS_BIT_SYNC] ? TX_SYNC : TX_GO;
            end
         end
         TX_SYNC: tx_st_d = TX_GO;
         TX_GO: tx_st_d = TX_IDLE;
         default: tx_st_d = TX_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         tx_st_q <= TX_IDLE;
         tx_sync_valid_q <= 1'b0;
         tx_sync_byte_q <= 8'h00;
         tx_launch_q <= 1'b0;
      end
      else
      begin
         tx_st_q <= tx_st_d;
         tx_sync_valid_q <= tx_st_d == TX_SYNC;
         tx_sync_byte_q <= `TMS_SYNC_BYTE;
         tx_launch_q <= tx_st_d == TX_GO;
      end
   end

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n_q);

   a_order_gated: assert property (
      rf_comm_active |=> !crc_high_bit_order_q)
      else $error("bit order active during rf communication");
   a_order_set: assert property (
      mode_q[7] && !rf_comm_active |=> crc_high_bit_order_q)
      else $error("bit order not applied");
   a_preset_map: assert property (
      !rf_comm_active && mode_q[1:0] == 2'b10 |=>
      checksum_preset_q == 16'hA671)
      else $error("preset code 10 wrong");
   a_preset_auto: assert property (
      rf_comm_active && !tx_active && receive_framing_setting == 2'b11
      |=> checksum_preset_q == 16'hFFFF)
      else $error("framing preset not used");
   a_sync_gate: assert property (
      mode_q[6] && rx_frame_start |=> !rx_receive_enable_q)
      else $error("receiver open before sync byte");
   a_sync_first: assert property (
      tx_st_q == TX_IDLE && tx_start_req && !tx_wait_needed && mode_q[6]
      |=> (tx_sync_valid_q && tx_sync_byte_q == 8'hF0) ##1 tx_launch_q)
      else $error("sync byte not sent first");
   a_tx_field_wait: assert property (
      tx_st_q == TX_WAIT_FIELD && tx_wait_needed |=> !tx_launch_q)
      else $error("launch without own field");
   a_rx_guard: assert property (
      mode_q[4] && target_role && !ext_field_detected |=>
      !receive_guard_counter_en_q)
      else $error("guard counter ran without field");
   a_env_polarity: assert property (
      mode_q[3] && envelope_input_pin |=> !envelope_active_n_q)
      else $error("envelope polarity wrong");
   a_pol_event: assert property (
      wr_mode && wb_dat_i[3] != mode_q[3] |=> status_q[0])
      else $error("polarity change raised no event");
   a_mode_det: assert property (
      !anticollision_busy |=> !mode_detector_en_q)
      else $error("mode detector outside anticollision");
   a_readback: assert property (
      wr_mode |=> mode_q == $past(wb_dat_i[7:0]))
      else $error("mode register lost write");

   c_pol_change: cover property (wr_mode && wb_dat_i[3] != mode_q[3]);
   c_sync_send: cover property (tx_sync_valid_q ##1 tx_launch_q);
   c_field_wait: cover property (tx_st_q == TX_WAIT_FIELD ##1 tx_launch_q);
   c_irq_clear: cover property (irq_q && rd_status ##2 !irq_q);

endmodule
`default_nettype wire

// [verif/tms_top_tb.sv]
// self-checking bench of the transceive mode settings block
`timescale 1ns/100ps
`default_nettype none
`include "tms_defines.svh"

`define TMS_CHK(g, e) \
   begin \
      check_count++; \
      if ((g) !== (e)) \
      begin \
         num_errors++; \
         $display("[ERR] %0t got %0h exp %0h", $time, g, e); \
      end \
   end

module tms_top_tb
   import tms_pkg::*;
;
   typedef struct packed
   {
      logic [7:0] mode;
      logic [15:0] pre;
      logic ord;
   } tms_row_type;
   tms_row_type rows [4] = '{{8'h80, 16'h0000, 1'b1}, {8'h41, 16'h6363, 1'b0},
      {8'h02, 16'hA671, 1'b0}, {8'hFF, 16'h0000, 1'b1}};
   logic [15:0] fr_exp [4] = '{16'h6363, 16'h0000, 16'h0000, 16'hFFFF};
   int num_errors = 0;
   int check_count = 0;
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
   logic wb_ack_o, irq_q, crc_high_bit_order_q, rx_receive_enable_q;
   logic rf_comm_active = 1'b0, tx_active = 1'b0;
   logic [1:0] receive_framing_setting = 2'h0, transmit_framing_setting = 2'h0;
   logic [15:0] checksum_preset_q;
   logic rx_frame_start = 1'b0, rx_byte_valid = 1'b0;
   logic [7:0] rx_byte = 8'h00, tx_sync_byte_q;
   logic tx_start_req = 1'b0, initiator_role = 1'b0, own_field_on = 1'b0;
   logic tx_sync_valid_q, tx_launch_q, receive_guard_counter_en_q;
   logic rx_guard_arm = 1'b0, target_role = 1'b0, ext_field_detected = 1'b0;
   logic envelope_input_pin = 1'b0, anticollision_busy = 1'b0;
   logic envelope_active_n_q, mode_detector_en_q, sync_seen;

   tms_top dut
   (
      .ref_clk(ref_clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .irq_q(irq_q), .rf_comm_active(rf_comm_active),
      .tx_active(tx_active),
      .receive_framing_setting(receive_framing_setting),
      .transmit_framing_setting(transmit_framing_setting),
      .crc_high_bit_order_q(crc_high_bit_order_q),
      .checksum_preset_q(checksum_preset_q),
      .rx_frame_start(rx_frame_start), .rx_byte_valid(rx_byte_valid),
      .rx_byte(rx_byte), .rx_receive_enable_q(rx_receive_enable_q),
      .tx_start_req(tx_start_req), .initiator_role(initiator_role),
      .own_field_on(own_field_on), .tx_sync_valid_q(tx_sync_valid_q),
      .tx_sync_byte_q(tx_sync_byte_q), .tx_launch_q(tx_launch_q),
      .rx_guard_arm(rx_guard_arm), .target_role(target_role),
      .ext_field_detected(ext_field_detected),
      .receive_guard_counter_en_q(receive_guard_counter_en_q),
      .envelope_input_pin(envelope_input_pin),
      .envelope_active_n_q(envelope_active_n_q),
      .anticollision_busy(anticollision_busy),
      .mode_detector_en_q(mode_detector_en_q)
   );

   initial
   begin
      forever #12.5 ref_clk = ~ref_clk;
   end

   // ****************************************************************
   // bus and helper tasks
   // ****************************************************************
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic wb_cycle(input logic we, input logic [7:0] adr,
      input logic [7:0] dat, output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge ref_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= 4'hF;
      wb_dat_i <= {24'h0, dat};
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 20);
      if (wb_ack_o !== 1'b1)
      begin
         num_errors++;
         tally_and_finish();
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
      logic [31:0] d;
      wb_cycle(1'b1, adr, dat, d);
   endtask

   task automatic chk_rd(input logic [7:0] adr, input logic [31:0] m,
      input logic [31:0] e);
      logic [31:0] d;
      wb_cycle(1'b0, adr, 8'h00, d);
      `TMS_CHK(d & m, e)
   endtask

   task automatic settle();
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask

   task automatic rx_pulse(input logic fs, input logic [7:0] b);
      @(posedge ref_clk);
      rx_frame_start <= fs;
      rx_byte_valid <= ~fs;
      rx_byte <= b;
      @(posedge ref_clk);
      rx_frame_start <= 1'b0;
      rx_byte_valid <= 1'b0;
      settle();
   endtask

   task automatic tx_req();
      @(posedge ref_clk);
      tx_start_req <= 1'b1;
      @(posedge ref_clk);
      tx_start_req <= 1'b0;
   endtask

   task automatic wait_launch();
      int n;
      n = 0;
      sync_seen = 1'b0;
      do
      begin
         @(negedge ref_clk);
         n++;
         if (tx_sync_valid_q === 1'b1)
         begin
            sync_seen = 1'b1;
            `TMS_CHK(tx_sync_byte_q, 8'hF0)
         end
      end
      while (tx_launch_q !== 1'b1 && n < 30);
      if (tx_launch_q !== 1'b1)
      begin
         num_errors++;
         tally_and_finish();
      end
   endtask

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial
   begin
      repeat (10) @(posedge ref_clk);
      `TMS_CHK(envelope_active_n_q, 1'b1)
      `TMS_CHK({irq_q, wb_ack_o, tx_launch_q}, 3'b000)
      arst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      chk_rd(`TMS_ADR_MODE, 32'hFFFFFFFF, 32'h3B);
      foreach (rows[i])
      begin
         wr(`TMS_ADR_MODE, rows[i].mode);
         settle();
         `TMS_CHK(checksum_preset_q, rows[i].pre)
         `TMS_CHK(crc_high_bit_order_q, rows[i].ord)
         chk_rd(`TMS_ADR_MODE, 32'hFFFFFFFF, {24'h0, rows[i].mode});
      end
      // communication overrides order bit and preset field
      wr(`TMS_ADR_MODE, 8'h82);
      rf_comm_active <= 1'b1;
      foreach (fr_exp[f])
      begin
         @(posedge ref_clk);
         receive_framing_setting <= 2'(f);
         settle();
         `TMS_CHK(checksum_preset_q, fr_exp[f])
         `TMS_CHK(crc_high_bit_order_q, 1'b0)
      end
      @(posedge ref_clk);
      tx_active <= 1'b1;
      transmit_framing_setting <= 2'h3;
      receive_framing_setting <= 2'h0;
      settle();
      `TMS_CHK(checksum_preset_q, 16'hFFFF)
      @(posedge ref_clk);
      rf_comm_active <= 1'b0;
      tx_active <= 1'b0;
      // unmapped place: read zero, write ignored
      chk_rd(8'h0C, 32'hFFFFFFFF, 32'h0);
      wr(8'h0C, 8'h55);
      chk_rd(`TMS_ADR_MODE, 32'hFFFFFFFF, 32'h82);
      // receive gate on sync byte
      wr(`TMS_ADR_MODE, 8'h40);
      rx_pulse(1'b1, 8'h00);
      `TMS_CHK(rx_receive_enable_q, 1'b0)
      rx_pulse(1'b0, 8'h55);
      `TMS_CHK(rx_receive_enable_q, 1'b0)
      chk_rd(`TMS_ADR_STATUS, 32'h2, 32'h0);
      rx_pulse(1'b0, 8'hF0);
      `TMS_CHK(rx_receive_enable_q, 1'b1)
      chk_rd(`TMS_ADR_STATUS, 32'h2, 32'h2);
      // transmit with and without sync byte, then waiting for field
      tx_req();
      wait_launch();
      `TMS_CHK(sync_seen, 1'b1)
      wr(`TMS_ADR_MODE, 8'h00);
      settle();
      `TMS_CHK(rx_receive_enable_q, 1'b1)
      tx_req();
      wait_launch();
      `TMS_CHK(sync_seen, 1'b0)
      wr(`TMS_ADR_MODE, 8'h20);
      initiator_role <= 1'b1;
      tx_req();
      repeat (8)
      begin
         @(negedge ref_clk);
         `TMS_CHK(tx_launch_q, 1'b0)
      end
      @(posedge ref_clk);
      own_field_on <= 1'b1;
      wait_launch();
      // receive guard counter waits for outside field
      wr(`TMS_ADR_MODE, 8'h10);
      target_role <= 1'b1;
      rx_guard_arm <= 1'b1;
      settle();
      `TMS_CHK(receive_guard_counter_en_q, 1'b0)
      @(posedge ref_clk);
      ext_field_detected <= 1'b1;
      settle();
      `TMS_CHK(receive_guard_counter_en_q, 1'b1)
      // mode detector
      @(posedge ref_clk);
      anticollision_busy <= 1'b1;
      settle();
      `TMS_CHK(mode_detector_en_q, 1'b1)
      wr(`TMS_ADR_MODE, 8'h14);
      settle();
      `TMS_CHK(mode_detector_en_q, 1'b0)
      wr(`TMS_ADR_MODE, 8'h00);
      anticollision_busy <= 1'b0;
      settle();
      `TMS_CHK(mode_detector_en_q, 1'b0)
      // envelope polarity, activity event and interrupt
      wr(`TMS_ADR_MODE, 8'h08);
      envelope_input_pin <= 1'b1;
      settle();
      `TMS_CHK(envelope_active_n_q, 1'b0)
      wr(`TMS_ADR_MASK, 8'h01);
      chk_rd(`TMS_ADR_MASK, 32'hFFFFFFFF, 32'h1);
      chk_rd(`TMS_ADR_STATUS, 32'h1, 32'h1);
      settle();
      `TMS_CHK(irq_q, 1'b0)
      wr(`TMS_ADR_MODE, 8'h00);
      settle();
      `TMS_CHK(envelope_active_n_q, 1'b1)
      `TMS_CHK(irq_q, 1'b1)
      chk_rd(`TMS_ADR_STATUS, 32'h1, 32'h1);
      settle();
      `TMS_CHK(irq_q, 1'b0)
      wr(`TMS_ADR_MODE, 8'h00);
      chk_rd(`TMS_ADR_STATUS, 32'h1, 32'h0);
      wr(`TMS_ADR_MASK, 8'h00);
      envelope_input_pin <= 1'b0;
      settle();
      `TMS_CHK(envelope_active_n_q, 1'b0)
      `TMS_CHK(irq_q, 1'b0)
      chk_rd(`TMS_ADR_STATUS, 32'h1, 32'h1);
      // second reset in mid-run
      @(posedge ref_clk);
      arst_n <= 1'b0;
      settle();
      `TMS_CHK(envelope_active_n_q, 1'b1)
      @(posedge ref_clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      chk_rd(`TMS_ADR_MODE, 32'hFFFFFFFF, 32'h3B);
      tally_and_finish();
   end
endmodule

`default_nettype wire
